// ==== legacy_status_pkg.sv ====
// Constants and helpers for the legacy compatibility status bits.
package legacy_status_pkg;

  // Data path and register bus widths.
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned ADDR_W   = 23;
  localparam int unsigned CNT_W    = 5;
  localparam int unsigned POS_W    = 4;
  localparam int unsigned SEL_W    = 2;

  // Word addresses of the second status register.
  localparam logic [ADDR_W-1:0] ADDR_NATIVE = 23'h000003;
  localparam logic [ADDR_W-1:0] ADDR_ALIAS  = 23'h000007;

  // Field positions inside the second status register.
  localparam int unsigned BIT_LOOP    = 15;
  localparam int unsigned BIT_DUAL    = 7;
  localparam int unsigned BIT_MODE    = 5;
  localparam int unsigned CNT_LSB     = 0;
  localparam logic [POS_W-1:0] POS_LOOP = 4'hF;
  localparam logic [POS_W-1:0] POS_DUAL = 4'h7;
  localparam logic [POS_W-1:0] POS_MODE = 4'h5;

  // Values after hardware reset.
  localparam logic             RST_LOOP = 1'h0;
  localparam logic             RST_DUAL = 1'h0;
  localparam logic             RST_MODE = 1'h1;
  localparam logic [CNT_W-1:0] RST_CNT  = 5'h00;
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;

  // The loop flag drops this many cycles after the counter reaches zero.
  localparam int unsigned LOOP_CLR_DELAY = 1;

  // Temporary register selectors of a native shift instruction.
  localparam logic [SEL_W-1:0] SEL_TEMP_ZERO  = 2'h0;
  localparam logic [SEL_W-1:0] SEL_TEMP_ONE   = 2'h1;
  localparam logic [SEL_W-1:0] SEL_TEMP_TWO   = 2'h2;
  localparam logic [SEL_W-1:0] SEL_TEMP_THREE = 2'h3;

  function automatic logic [DATA_W-1:0] sext_count(
    input logic [CNT_W-1:0] cnt
  );
    sext_count = {{(DATA_W-CNT_W){cnt[CNT_W-1]}}, cnt};
  endfunction : sext_count

  // Builds the register image; unmodelled bits read as zero.
  function automatic logic [DATA_W-1:0] pack_status(
    input logic             loop_flag,
    input logic             dual,
    input logic             mode,
    input logic [CNT_W-1:0] cnt
  );
    logic [DATA_W-1:0] w;
    w                        = RST_WORD;
    w[BIT_LOOP]              = loop_flag;
    w[BIT_DUAL]              = dual;
    w[BIT_MODE]              = mode;
    w[CNT_LSB+CNT_W-1:CNT_LSB] = cnt;
    pack_status              = w;
  endfunction : pack_status

endpackage : legacy_status_pkg

// ==== shift_source_sel.sv ====
// Chooses the accumulator shift amount for the current instruction.
`timescale 1ns/1ps
module shift_source_sel
  import legacy_status_pkg::*;
(
  // Mode and request
  input  wire logic              i_legacy,
  input  wire logic              i_legacy_req,
  input  wire logic              i_use_const,
  input  wire logic [SEL_W-1:0]  i_sel,
  input  wire logic [DATA_W-1:0] i_const,
  // Temporary registers
  input  wire logic [DATA_W-1:0] i_temp_zero,
  input  wire logic [DATA_W-1:0] i_temp_one,
  input  wire logic [DATA_W-1:0] i_temp_two,
  input  wire logic [DATA_W-1:0] i_temp_three,
  // Result
  output logic      [DATA_W-1:0] o_amount
);

  always_comb begin
    if (i_legacy && i_legacy_req) begin
      // The legacy count always lives in the tied temporary register.
      o_amount = i_temp_two;
    end else if (i_use_const) begin
      o_amount = i_const;
    end else begin
      case (i_sel)
        SEL_TEMP_ZERO:  o_amount = i_temp_zero;
        SEL_TEMP_ONE:   o_amount = i_temp_one;
        SEL_TEMP_TWO:   o_amount = i_temp_two;
        SEL_TEMP_THREE: o_amount = i_temp_three;
        default:        o_amount = i_temp_zero;
      endcase
    end
  end

endmodule : shift_source_sel

// ==== repeat_counter.sv ====
// Repeat counter with end-of-loop decision and delayed flag clear.
`timescale 1ns/1ps
module repeat_counter
  import legacy_status_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Loop control
  input  wire logic              i_legacy,
  input  wire logic              i_flag,
  input  wire logic              i_last_decode,
  // Counter write
  input  wire logic              i_cnt_we,
  input  wire logic [DATA_W-1:0] i_cnt_wdata,
  // Results
  output logic      [DATA_W-1:0] o_cnt,
  output logic                   o_repeat,
  output logic                   o_end,
  output logic                   o_clr_req
);

  typedef struct packed {
    logic [DATA_W-1:0] cnt;
    logic              clr_pend;
  } cnt_state_s;

  cnt_state_s r_reg;
  cnt_state_s r_next;
  logic       go_on;

  assign go_on = i_legacy && i_flag && (r_reg.cnt != 16'h0000);

  always_comb begin
    r_next          = r_reg;
    r_next.clr_pend = 1'b0;
    if (i_cnt_we) begin
      r_next.cnt = i_cnt_wdata;
      // Not pipeline protected: the flag drops one cycle later.
      if (i_cnt_wdata == 16'h0000) begin
        r_next.clr_pend = i_legacy;
      end
    end else if (i_legacy && i_last_decode && go_on) begin
      r_next.cnt = r_reg.cnt - 16'h0001;
      if (r_reg.cnt == 16'h0001) begin
        r_next.clr_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_reg <= '{cnt: RST_WORD, clr_pend: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_cnt     = r_reg.cnt;
  assign o_repeat  = i_legacy && i_last_decode && go_on;
  assign o_end     = i_legacy && i_last_decode && !go_on;
  assign o_clr_req = r_reg.clr_pend;

endmodule : repeat_counter

// ==== legacy_status_bits.sv ====
// Legacy compatibility fields of the second core status register.
//
// Functional notes
// - Shift-count field in bits 4..0, read/write, zero after reset.
// - Register reachable at native address and legacy alias, same storage.
// - Legacy alias write sign-extends shift count into temp two; no bit ops.
// - Legacy shift request takes its amount from temp two.
// - Legacy mode: every temp two load copies low five bits to field.
// - Native mode ignores field; shift from named temp or constant.
// - Native mode: alias writes and temp two writes stay independent.
// - Mode turned on by same write decides the temp two extension.
// - Loop flag at bit 15, read/write, reset zero, unused natively.
// - Mode turned on by same write decides how loop flag acts; the loop logic here uses the stored mode bit, the old mode in that cycle.
// - Block repeat address phase sets the loop flag.
// - Last loop instruction decode: repeat with decrement or end loop.
// - Counter decremented to zero clears loop flag one cycle later.
// - Writing zero to counter clears loop flag one cycle later.
// - Far jump or far call clears flag; other branches leave it.
// - Bit set, bit clear and register writes set or clear flag.
// - Flag saved on interrupt entry, restored on interrupt return.
// - Flag updates before a return are visible right after it.
// - Dual arithmetic bit 7, reset zero, effective only in legacy.
// - Legacy mode bit 5, reset one; one selects legacy behaviour.
`timescale 1ns/1ps
module legacy_status_bits
  import legacy_status_pkg::*;
(
  // Clock and reset
  input  wire logic                                     I_MCLK,
  input  wire logic                                     I_RST,
  // Memory-mapped register access
  input  wire logic                                     I_REG_WE,
  input  wire logic                                     I_REG_RE,
  input  wire logic [legacy_status_pkg::ADDR_W-1:0]     I_REG_ADDR,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_REG_WDATA,
  output logic      [legacy_status_pkg::DATA_W-1:0]     O_REG_RDATA,
  output logic                                          O_REG_HIT,
  // Status bit set and clear instructions
  input  wire logic                                     I_BIT_SET,
  input  wire logic                                     I_BIT_CLR,
  input  wire logic [legacy_status_pkg::POS_W-1:0]      I_BIT_POS,
  // Temporary register two load
  input  wire logic                                     I_TEMP_TWO_WE,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_TEMP_TWO_WDATA,
  output logic      [legacy_status_pkg::DATA_W-1:0]     O_TEMP_TWO,
  // Shift amount selection
  input  wire logic                                     I_SHIFT_LEGACY_REQ,
  input  wire logic                                     I_SHIFT_USE_CONST,
  input  wire logic [legacy_status_pkg::SEL_W-1:0]      I_SHIFT_SEL,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_SHIFT_CONST,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_TEMP_ZERO,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_TEMP_ONE,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_TEMP_THREE,
  output logic      [legacy_status_pkg::DATA_W-1:0]     O_SHIFT_AMOUNT,
  // Block repeat pipeline strobes
  input  wire logic                                     I_RPT_START_AD,
  input  wire logic                                     I_LAST_DECODE,
  input  wire logic                                     I_RPT_CNT_WE,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_RPT_CNT_WDATA,
  output logic      [legacy_status_pkg::DATA_W-1:0]     O_RPT_CNT,
  output logic                                          O_LOOP_REPEAT,
  output logic                                          O_LOOP_END,
  // Program flow events
  input  wire logic                                     I_FAR_JUMP,
  input  wire logic                                     I_IRQ_ENTRY,
  input  wire logic                                     I_IRQ_RETURN,
  input  wire logic [legacy_status_pkg::DATA_W-1:0]     I_RESTORE_DATA,
  input  wire logic                                     I_RETURN_PROTECT,
  output logic      [legacy_status_pkg::DATA_W-1:0]     O_SAVE_DATA,
  output logic                                          O_SAVE_VALID,
  // Mode outputs
  output logic                                          O_LEGACY_MODE,
  output logic                                          O_DUAL_HALF_ACTIVE,
  output logic                                          O_LOOP_ACTIVE
);
  import legacy_status_pkg::*;

  typedef struct packed {
    logic              loop_active_flag;
    logic              dual_half_arith_mode;
    logic              legacy_compat_mode;
    logic [CNT_W-1:0]  acc_shift_count_field;
    logic [DATA_W-1:0] temp_reg_two;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] shift_amount;
    logic [DATA_W-1:0] save_data;
    logic              save_valid;
  } status_state_s;

  status_state_s r_reg;
  status_state_s r_next;

  logic              wr_native;
  logic              wr_alias;
  logic              wr_any;
  logic              rd_hit;
  logic              mode_after;
  logic              bit_set_loop;
  logic              bit_clr_loop;
  logic              clr_req;
  logic [DATA_W-1:0] shift_pick;
  logic [DATA_W-1:0] image_now;
  logic [DATA_W-1:0] image_next;

  // Address decode: two addresses, one storage.
  assign wr_native = I_REG_WE && (I_REG_ADDR == ADDR_NATIVE);
  assign wr_alias  = I_REG_WE && (I_REG_ADDR == ADDR_ALIAS);
  assign wr_any    = wr_native || wr_alias;
  assign rd_hit    = I_REG_RE && ((I_REG_ADDR == ADDR_NATIVE) ||
                                  (I_REG_ADDR == ADDR_ALIAS));
  assign O_REG_HIT = (I_REG_WE || I_REG_RE) &&
                     ((I_REG_ADDR == ADDR_NATIVE) ||
                      (I_REG_ADDR == ADDR_ALIAS));

  // A register write that also flips the mode acts under the new mode.
  assign mode_after = wr_any ? I_REG_WDATA[BIT_MODE]
                             : r_reg.legacy_compat_mode;

  assign bit_set_loop = I_BIT_SET && (I_BIT_POS == POS_LOOP);
  assign bit_clr_loop = I_BIT_CLR && (I_BIT_POS == POS_LOOP);

  assign image_now = pack_status(r_reg.loop_active_flag,
                                 r_reg.dual_half_arith_mode,
                                 r_reg.legacy_compat_mode,
                                 r_reg.acc_shift_count_field);
  assign image_next = pack_status(r_next.loop_active_flag,
                                  r_next.dual_half_arith_mode,
                                  r_next.legacy_compat_mode,
                                  r_next.acc_shift_count_field);

  shift_source_sel u_shift_sel (
    .i_legacy     (r_reg.legacy_compat_mode),
    .i_legacy_req (I_SHIFT_LEGACY_REQ),
    .i_use_const  (I_SHIFT_USE_CONST),
    .i_sel        (I_SHIFT_SEL),
    .i_const      (I_SHIFT_CONST),
    .i_temp_zero  (I_TEMP_ZERO),
    .i_temp_one   (I_TEMP_ONE),
    .i_temp_two   (r_reg.temp_reg_two),
    .i_temp_three (I_TEMP_THREE),
    .o_amount     (shift_pick)
  );

  // The counter sees the flag only while legacy mode is on.
  repeat_counter u_rpt_cnt (
    .i_clk         (I_MCLK),
    .i_rst         (I_RST),
    .i_legacy      (r_reg.legacy_compat_mode),
    .i_flag        (r_reg.loop_active_flag),
    .i_last_decode (I_LAST_DECODE),
    .i_cnt_we      (I_RPT_CNT_WE),
    .i_cnt_wdata   (I_RPT_CNT_WDATA),
    .o_cnt         (O_RPT_CNT),
    .o_repeat      (O_LOOP_REPEAT),
    .o_end         (O_LOOP_END),
    .o_clr_req     (clr_req)
  );

  always_comb begin
    r_next            = r_reg;
    r_next.save_valid = 1'b0;

    // Hardware and program flow clears come first so that any set in
    // the same cycle, by software or by a new loop, wins over them.
    if (clr_req) begin
      r_next.loop_active_flag = 1'b0;
    end
    if (I_FAR_JUMP) begin
      r_next.loop_active_flag = 1'b0;
    end

    // Single bit instructions; the shift-count field takes none.
    if (bit_clr_loop) begin
      r_next.loop_active_flag = 1'b0;
    end
    if (bit_set_loop) begin
      r_next.loop_active_flag = 1'b1;
    end
    if (I_BIT_CLR && (I_BIT_POS == POS_DUAL)) begin
      r_next.dual_half_arith_mode = 1'b0;
    end
    if (I_BIT_SET && (I_BIT_POS == POS_DUAL)) begin
      r_next.dual_half_arith_mode = 1'b1;
    end
    if (I_BIT_CLR && (I_BIT_POS == POS_MODE)) begin
      r_next.legacy_compat_mode = 1'b0;
    end
    if (I_BIT_SET && (I_BIT_POS == POS_MODE)) begin
      r_next.legacy_compat_mode = 1'b1;
    end

    // Whole register write through either address.
    if (wr_any) begin
      r_next.loop_active_flag      = I_REG_WDATA[BIT_LOOP];
      r_next.dual_half_arith_mode  = I_REG_WDATA[BIT_DUAL];
      r_next.legacy_compat_mode    = I_REG_WDATA[BIT_MODE];
      r_next.acc_shift_count_field =
        I_REG_WDATA[CNT_LSB+CNT_W-1:CNT_LSB];
    end

    // Return from interrupt brings back the saved register image.
    if (I_IRQ_RETURN) begin
      r_next.loop_active_flag      = I_RESTORE_DATA[BIT_LOOP];
      r_next.dual_half_arith_mode  = I_RESTORE_DATA[BIT_DUAL];
      r_next.legacy_compat_mode    = I_RESTORE_DATA[BIT_MODE];
      r_next.acc_shift_count_field =
        I_RESTORE_DATA[CNT_LSB+CNT_W-1:CNT_LSB];
    end

    // A new loop marks itself active in its address phase.
    if (I_RPT_START_AD) begin
      r_next.loop_active_flag = 1'b1;
    end

    // Temporary register two and the shift-count field are tied
    // together only in legacy mode.
    if (I_TEMP_TWO_WE) begin
      r_next.temp_reg_two = I_TEMP_TWO_WDATA;
      if (r_reg.legacy_compat_mode) begin
        r_next.acc_shift_count_field =
          I_TEMP_TWO_WDATA[CNT_W-1:0];
      end
    end
    if (wr_alias && mode_after) begin
      r_next.temp_reg_two = sext_count(
        I_REG_WDATA[CNT_LSB+CNT_W-1:CNT_LSB]);
    end

    // Reads through either address see one image. Around a return the
    // update of this very cycle is forwarded, so the first instruction
    // after the return never reads a stale flag.
    if (rd_hit) begin
      r_next.rdata = I_RETURN_PROTECT ? image_next
                                      : image_now;
    end

    // Interrupt entry captures the image for the data stack; a plain
    // call does not reach this port.
    if (I_IRQ_ENTRY) begin
      r_next.save_data  = image_now;
      r_next.save_valid = 1'b1;
    end

    r_next.shift_amount = shift_pick;
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      r_reg.loop_active_flag      <= RST_LOOP;
      r_reg.dual_half_arith_mode  <= RST_DUAL;
      r_reg.legacy_compat_mode    <= RST_MODE;
      r_reg.acc_shift_count_field <= RST_CNT;
      r_reg.temp_reg_two          <= RST_WORD;
      r_reg.rdata                 <= RST_WORD;
      r_reg.shift_amount          <= RST_WORD;
      r_reg.save_data             <= RST_WORD;
      r_reg.save_valid            <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign O_REG_RDATA    = r_reg.rdata;
  assign O_TEMP_TWO     = r_reg.temp_reg_two;
  assign O_SHIFT_AMOUNT = r_reg.shift_amount;
  assign O_SAVE_DATA    = r_reg.save_data;
  assign O_SAVE_VALID   = r_reg.save_valid;
  assign O_LEGACY_MODE  = r_reg.legacy_compat_mode;

  // The dual mode and the loop flag have no effect outside legacy mode.
  assign O_DUAL_HALF_ACTIVE = r_reg.legacy_compat_mode &&
                              r_reg.dual_half_arith_mode;
  assign O_LOOP_ACTIVE      = r_reg.legacy_compat_mode &&
                              r_reg.loop_active_flag;

endmodule : legacy_status_bits

// ==== legacy_status_bits_props.sv ====
// Concurrent checks on the ports of the legacy status bit block.
`timescale 1ns/1ps
module legacy_status_bits_props
  import legacy_status_pkg::*;
(
  // Clock, reset and register bus
  input wire logic              I_MCLK, I_RST, I_REG_WE, I_REG_RE,
  input wire logic [ADDR_W-1:0] I_REG_ADDR,
  input wire logic [DATA_W-1:0] I_REG_WDATA, O_REG_RDATA, O_TEMP_TWO,
  input wire logic              O_REG_HIT, I_BIT_SET, I_RETURN_PROTECT,
  // Loop, flow and shift signals
  input wire logic [DATA_W-1:0] O_RPT_CNT, O_SAVE_DATA, O_SHIFT_AMOUNT,
  input wire logic [DATA_W-1:0] I_RPT_CNT_WDATA, I_RESTORE_DATA,
  input wire logic              I_RPT_START_AD, I_LAST_DECODE, I_RPT_CNT_WE,
  input wire logic              I_FAR_JUMP, I_IRQ_ENTRY, I_IRQ_RETURN,
  input wire logic              I_SHIFT_LEGACY_REQ, O_LOOP_REPEAT, O_LOOP_END,
  input wire logic              O_SAVE_VALID, O_LEGACY_MODE,
  input wire logic              O_DUAL_HALF_ACTIVE, O_LOOP_ACTIVE
);
  logic [DATA_W-1:0] wd_q;
  // Nothing that can set the loop flag is active in this cycle.
  wire quiet = !I_RPT_START_AD && !I_BIT_SET && !I_REG_WE && !I_IRQ_RETURN;

  always_ff @(posedge I_MCLK) begin
    wd_q <= I_REG_WDATA;
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  sequence s_dec_zero;
    I_LAST_DECODE && O_LOOP_ACTIVE && O_RPT_CNT == 16'h1 && !I_RPT_CNT_WE;
  endsequence
  sequence s_cnt_zero;
    I_RPT_CNT_WE && I_RPT_CNT_WDATA == 16'h0 && O_LEGACY_MODE;
  endsequence

  property p_hit;
    O_REG_HIT == ((I_REG_WE || I_REG_RE) &&
      (I_REG_ADDR == ADDR_NATIVE || I_REG_ADDR == ADDR_ALIAS));
  endproperty
  property p_alias;
    I_REG_WE && I_REG_ADDR == ADDR_ALIAS && I_REG_WDATA[BIT_MODE]
      |=> O_TEMP_TWO == {{11{wd_q[4]}}, wd_q[4:0]};
  endproperty
  property p_read;
    I_REG_RE && O_REG_HIT && !I_RETURN_PROTECT
      |=> O_REG_RDATA[BIT_MODE] == $past(O_LEGACY_MODE);
  endproperty
  property p_dual;
    I_REG_WE && O_REG_HIT && !I_IRQ_RETURN
      |=> O_DUAL_HALF_ACTIVE == (wd_q[BIT_DUAL] && wd_q[BIT_MODE]);
  endproperty
  property p_start;
    I_RPT_START_AD && O_LEGACY_MODE |=> !O_LEGACY_MODE || O_LOOP_ACTIVE;
  endproperty
  property p_repeat;
    I_LAST_DECODE && O_LOOP_ACTIVE && O_RPT_CNT != 16'h0 && !I_RPT_CNT_WE
      |-> (O_LOOP_REPEAT && !O_LOOP_END) ##1
          O_RPT_CNT == $past(O_RPT_CNT) - 16'h1;
  endproperty
  property p_end;
    I_LAST_DECODE && O_LEGACY_MODE && (!O_LOOP_ACTIVE || O_RPT_CNT == 16'h0)
      |-> O_LOOP_END && !O_LOOP_REPEAT;
  endproperty
  property p_dec_clear;
    s_dec_zero ##1 quiet |=> !O_LOOP_ACTIVE;
  endproperty
  property p_cnt_clear;
    s_cnt_zero ##1 (quiet && O_LOOP_ACTIVE) |=> !O_LOOP_ACTIVE;
  endproperty
  property p_far;
    I_FAR_JUMP && quiet |=> !O_LOOP_ACTIVE;
  endproperty
  property p_save;
    I_IRQ_ENTRY |=> O_SAVE_VALID &&
      O_SAVE_DATA[BIT_MODE] == $past(O_LEGACY_MODE) &&
      (O_SAVE_DATA[BIT_LOOP] && O_SAVE_DATA[BIT_MODE]) == $past(O_LOOP_ACTIVE);
  endproperty
  property p_restore;
    I_IRQ_RETURN && !I_RPT_START_AD
      |=> O_LEGACY_MODE == $past(I_RESTORE_DATA[BIT_MODE]);
  endproperty
  property p_shift;
    I_SHIFT_LEGACY_REQ && O_LEGACY_MODE |=> O_SHIFT_AMOUNT == $past(O_TEMP_TWO);
  endproperty

  a_hit: assert property (p_hit) else $error("hit flag wrong");
  a_alias: assert property (p_alias) else $error("temp two not extended");
  a_read: assert property (p_read) else $error("read image wrong");
  a_dual: assert property (p_dual) else $error("dual mode wrong");
  a_start: assert property (p_start) else $error("loop not set");
  a_repeat: assert property (p_repeat) else $error("no repeat");
  a_end: assert property (p_end) else $error("no loop end");
  a_dec_clear: assert property (p_dec_clear) else $error("flag kept");
  a_cnt_clear: assert property (p_cnt_clear) else $error("flag kept");
  a_far: assert property (p_far) else $error("far flow kept flag");
  a_save: assert property (p_save) else $error("save image wrong");
  a_restore: assert property (p_restore) else $error("restore wrong");
  a_shift: assert property (p_shift) else $error("legacy shift wrong");
endmodule : legacy_status_bits_props

bind legacy_status_bits legacy_status_bits_props u_props (.*);

// ==== legacy_compat_status_bits_test.sv ====
// Self-checking testbench of the legacy status bit block.
`timescale 1ns/1ps
module legacy_compat_status_bits_test;
  import legacy_status_pkg::*;

  logic I_MCLK, I_RST, I_REG_WE, I_REG_RE, I_BIT_SET, I_BIT_CLR;
  logic I_TEMP_TWO_WE, I_SHIFT_LEGACY_REQ, I_SHIFT_USE_CONST, I_FAR_JUMP;
  logic I_RPT_START_AD, I_LAST_DECODE, I_RPT_CNT_WE, I_IRQ_ENTRY;
  logic I_IRQ_RETURN, I_RETURN_PROTECT, O_REG_HIT, O_LOOP_REPEAT;
  logic O_LOOP_END, O_SAVE_VALID, O_LEGACY_MODE, O_DUAL_HALF_ACTIVE;
  logic O_LOOP_ACTIVE;
  logic [ADDR_W-1:0] I_REG_ADDR;
  logic [POS_W-1:0]  I_BIT_POS;
  logic [SEL_W-1:0]  I_SHIFT_SEL;
  logic [DATA_W-1:0] I_REG_WDATA, I_TEMP_TWO_WDATA, I_SHIFT_CONST;
  logic [DATA_W-1:0] I_TEMP_ZERO, I_TEMP_ONE, I_TEMP_THREE, I_RPT_CNT_WDATA;
  logic [DATA_W-1:0] I_RESTORE_DATA, O_REG_RDATA, O_TEMP_TWO, O_RPT_CNT;
  logic [DATA_W-1:0] O_SHIFT_AMOUNT, O_SAVE_DATA;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  legacy_status_bits uut (.*);

  initial begin
    I_MCLK = 1'b0;
    forever #12.5 I_MCLK = ~I_MCLK;
  end

  function automatic logic [15:0] sx5(input logic [4:0] c);
    sx5 = {{11{c[4]}}, c};
  endfunction : sx5

  // Only the loop flag, dual bit, mode bit and count field are stored.
  function automatic logic [15:0] img(input logic [15:0] d);
    img = d & 16'h80BF;
  endfunction : img

  // Temp two still holds the extended count of the last alias write.
  function automatic logic [15:0] pick(input int s);
    case (s)
      0: pick = I_TEMP_ZERO;
      1: pick = I_TEMP_ONE;
      2: pick = 16'hFFF1;
      3: pick = I_TEMP_THREE;
      default: pick = I_SHIFT_CONST;
    endcase
  endfunction : pick

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chb(input string nm, input logic seen, exp);
    chk(nm, {15'h0, seen}, {15'h0, exp});
  endtask : chb

  task automatic tick;
    @(posedge I_MCLK);
    #1;
  endtask : tick

  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    I_REG_WE = 1'b1;
    I_REG_ADDR = a;
    I_REG_WDATA = d;
    tick;
    I_REG_WE = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [22:0] a, input logic [15:0] e,
                        input string nm);
    I_REG_RE = 1'b1;
    I_REG_ADDR = a;
    tick;
    I_REG_RE = 1'b0;
    chk(nm, O_REG_RDATA, e);
  endtask : rd_chk

  task automatic ld(input logic [15:0] d);
    I_TEMP_TWO_WE = 1'b1;
    I_TEMP_TWO_WDATA = d;
    tick;
    I_TEMP_TWO_WE = 1'b0;
  endtask : ld

  task automatic cnt_wr(input logic [15:0] d);
    I_RPT_CNT_WE = 1'b1;
    I_RPT_CNT_WDATA = d;
    tick;
    I_RPT_CNT_WE = 1'b0;
  endtask : cnt_wr

  task automatic bitop(input logic set, input logic [3:0] pos);
    I_BIT_SET = set;
    I_BIT_CLR = !set;
    I_BIT_POS = pos;
    tick;
    I_BIT_SET = 1'b0;
    I_BIT_CLR = 1'b0;
  endtask : bitop

  task automatic done(input string nm);
    $display("Test %s finished", nm);
  endtask : done

  always @(posedge I_MCLK) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    logic [15:0] d;
    {I_REG_WE, I_REG_RE, I_BIT_SET, I_BIT_CLR, I_TEMP_TWO_WE} = '0;
    {I_SHIFT_LEGACY_REQ, I_SHIFT_USE_CONST, I_FAR_JUMP, I_RPT_START_AD} = '0;
    {I_LAST_DECODE, I_RPT_CNT_WE, I_IRQ_ENTRY, I_IRQ_RETURN} = '0;
    {I_RETURN_PROTECT, I_REG_ADDR, I_BIT_POS, I_SHIFT_SEL} = '0;
    {I_REG_WDATA, I_TEMP_TWO_WDATA, I_SHIFT_CONST, I_RPT_CNT_WDATA} = '0;
    I_RESTORE_DATA = 16'h0000;
    I_RST = 1'b1;
    void'($urandom(32'h320F));
    I_TEMP_ZERO = 16'($urandom);
    I_TEMP_ONE = 16'($urandom);
    I_TEMP_THREE = 16'($urandom);
    repeat (20) @(posedge I_MCLK);
    #1;
    I_RST = 1'b0;
    rd_chk(ADDR_NATIVE, 16'h0020, "reset image");
    done("reset");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0080 : 16'($urandom);
      wr(ADDR_NATIVE, d);
      chb("dual mode", O_DUAL_HALF_ACTIVE, d[7] & d[5]);
      rd_chk(ADDR_ALIAS, img(d), "alias read");
      rd_chk(ADDR_NATIVE, img(d), "native read");
    end
    wr(23'h000004, 16'h0000);
    rd_chk(ADDR_NATIVE, img(d), "unmapped write");
    done("registers");
    wr(ADDR_NATIVE, 16'h0020);
    wr(ADDR_ALIAS, 16'h0033);
    chk("temp extend", O_TEMP_TWO, sx5(5'h13));
    ld(16'h1234);
    rd_chk(ADDR_NATIVE, 16'h0034, "count copy");
    bitop(1'b0, 4'h2);
    rd_chk(ADDR_NATIVE, 16'h0034, "count bit op");
    wr(ADDR_NATIVE, 16'h0000);
    wr(ADDR_ALIAS, 16'h001F);
    chk("temp native", O_TEMP_TWO, 16'h1234);
    ld(16'h0005);
    rd_chk(ADDR_NATIVE, 16'h001F, "count native");
    wr(ADDR_ALIAS, 16'h0031);
    chk("temp mode on", O_TEMP_TWO, sx5(5'h11));
    done("temp two");
    I_SHIFT_LEGACY_REQ = 1'b1;
    tick;
    chk("legacy shift", O_SHIFT_AMOUNT, 16'hFFF1);
    wr(ADDR_NATIVE, 16'h0000);
    for (int s = 0; s < 5; s++) begin
      I_SHIFT_SEL = s[1:0];
      I_SHIFT_USE_CONST = (s == 4);
      I_SHIFT_CONST = 16'($urandom);
      tick;
      chk("native shift", O_SHIFT_AMOUNT, pick(s));
    end
    I_SHIFT_LEGACY_REQ = 1'b0;
    I_SHIFT_USE_CONST = 1'b0;
    done("shift");
    wr(ADDR_NATIVE, 16'h0020);
    cnt_wr(16'h0002);
    I_RPT_START_AD = 1'b1;
    tick;
    I_RPT_START_AD = 1'b0;
    chb("loop set", O_LOOP_ACTIVE, 1'b1);
    repeat (5) tick;
    for (int k = 2; k >= 0; k--) begin
      I_LAST_DECODE = 1'b1;
      #1;
      chb("repeat", O_LOOP_REPEAT, k != 0);
      chb("end", O_LOOP_END, k == 0);
      tick;
      I_LAST_DECODE = 1'b0;
      tick;
      chk("counter", O_RPT_CNT, (k != 0) ? 16'(k - 1) : 16'h0);
      chb("loop flag", O_LOOP_ACTIVE, k > 1);
    end
    bitop(1'b1, 4'hF);
    chb("bit set", O_LOOP_ACTIVE, 1'b1);
    cnt_wr(16'h0000);
    chb("flag held", O_LOOP_ACTIVE, 1'b1);
    tick;
    chb("flag dropped", O_LOOP_ACTIVE, 1'b0);
    bitop(1'b1, 4'hF);
    I_FAR_JUMP = 1'b1;
    tick;
    I_FAR_JUMP = 1'b0;
    chb("far flow", O_LOOP_ACTIVE, 1'b0);
    bitop(1'b1, 4'hF);
    bitop(1'b0, 4'hF);
    chb("bit clear", O_LOOP_ACTIVE, 1'b0);
    done("loop");
    bitop(1'b1, 4'hF);
    I_IRQ_ENTRY = 1'b1;
    tick;
    I_IRQ_ENTRY = 1'b0;
    chb("save valid", O_SAVE_VALID, 1'b1);
    chk("save image", O_SAVE_DATA, 16'h8020);
    wr(ADDR_NATIVE, 16'h0000);
    I_IRQ_RETURN = 1'b1;
    I_RESTORE_DATA = 16'h8020;
    tick;
    I_IRQ_RETURN = 1'b0;
    rd_chk(ADDR_NATIVE, 16'h8020, "restore");
    {I_REG_WE, I_REG_RE, I_RETURN_PROTECT} = 3'h7;
    I_REG_ADDR = ADDR_NATIVE;
    I_REG_WDATA = 16'h0000;
    tick;
    {I_REG_WE, I_REG_RE, I_RETURN_PROTECT} = 3'h0;
    chk("protected read", O_REG_RDATA, 16'h0000);
    done("context");
    final_report();
  end
endmodule : legacy_compat_status_bits_test
